// ---- hw/opd_pkg.sv ----
package opd_pkg;

    // Serial frame layout
    localparam int          FRAME_CMD_BITS   = 16;
    localparam int          FRAME_BITS       = 24;
    localparam logic [4:0]  CMD_LAST_CNT     = 5'h0F;
    localparam logic [4:0]  FRAME_LAST_CNT   = 5'h17;

    // Register offsets
    localparam logic [14:0] OFS_IFACE_CFG    = 15'h0007;
    localparam logic [14:0] OFS_POWER_DOWN   = 15'h0008;
    localparam logic [14:0] OFS_DRV_DIS_LOW  = 15'h000A;
    localparam logic [14:0] OFS_DRV_DIS_MID  = 15'h000B;
    localparam logic [14:0] OFS_DRV_DIS_HIGH = 15'h000C;
    localparam logic [14:0] OFS_SLEEP_MASK   = 15'h000D;
    localparam logic [14:0] OFS_FUSE_LOAD    = 15'h0013;

    // Field positions
    localparam int          POS_MAP_LSB      = 5;
    localparam int          POS_PERMIT       = 3;
    localparam int          POS_SEL_LSB      = 0;
    localparam int          POS_CLKBUF_OFF   = 5;
    localparam int          POS_REFAMP_OFF   = 4;
    localparam int          POS_CHA_OFF      = 2;
    localparam int          POS_CHB_OFF      = 1;
    localparam int          POS_SLEEP        = 0;
    localparam int          POS_KEEP_CLKBUF  = 3;
    localparam int          POS_FUSE_LOAD    = 0;

    // Values after reset
    localparam logic [7:0]  RST_BYTE         = 8'h00;
    localparam logic [2:0]  RST_FIELD3       = 3'h0;
    localparam logic [23:0] RST_DRV_DIS      = 24'h00_0000;

    // Lane bit mapping codes
    localparam logic [2:0]  MAP_2W_18_14     = 3'h1;
    localparam logic [2:0]  MAP_2W_20_16     = 3'h2;
    localparam logic [2:0]  MAP_1W           = 3'h3;
    localparam logic [2:0]  MAP_HALF_W       = 3'h4;

    // Interface selection codes
    localparam logic [2:0]  SEL_2W           = 3'h3;
    localparam logic [2:0]  SEL_1W           = 3'h4;
    localparam logic [2:0]  SEL_HALF_W       = 3'h5;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_CMD  = 2'b01,
        ST_DATA = 2'b11,
        ST_DONE = 2'b10
    } opd_state_t;

endpackage

// ---- hw/opd_regs.sv ----
`timescale 1ns/100ps
module opd_regs
    import opd_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        reset,
    input  wire logic        spi_sclk,
    input  wire logic        spi_sen_n,
    input  wire logic        spi_sdi,
    output logic             spi_sdo,
    output logic             spi_sdo_oe,
    input  wire logic [2:0]  fuse_lane_mapping,
    input  wire logic [2:0]  fuse_interface_selection,
    output logic [3:0]       lane_mode,
    output logic [2:0]       interface_mode,
    output logic             sample_clock_buffer_off,
    output logic             reference_amp_off,
    output logic             channel_a_off,
    output logic             channel_b_off,
    output logic             whole_chip_sleep,
    output logic [23:0]      output_driver_disable
);
    typedef struct packed {
        opd_state_t  state;
        logic [4:0]  bit_cnt;
        logic [22:0] shift_in;
        logic [7:0]  shift_out;
        logic        sclk_q;
        logic        sdo;
        logic        sdo_oe;
        logic [2:0]  lane_bit_mapping;
        logic        interface_change_permit;
        logic [2:0]  interface_selection;
        logic        clkbuf_pd;
        logic        refamp_pd;
        logic        cha_pd;
        logic        chb_pd;
        logic        sleep;
        logic [23:0] drv_dis;
        logic        keep_clock_buffer_in_sleep;
        logic [2:0]  active_map;
        logic        wr_pulse;
        logic        fuse_pulse;
        logic [3:0]  lane_mode;
        logic [2:0]  interface_mode;
        logic [4:0]  off_vec;
        logic [23:0] drv_out;
    } opd_st_t;

    opd_st_t    r;
    opd_st_t    next_r;
    logic [2:0] pins;

    // Select enters inverted so the reset level reads as idle
    opd_sync #(.W(3)) u_sync (
        .ref_clk  (ref_clk),
        .reset    (reset),
        .async_in ({spi_sclk, ~spi_sen_n, spi_sdi}),
        .sync_out (pins)
    );

    function automatic logic [3:0] map_decode(input logic [2:0] code);
        map_decode = 4'h0;
        unique case (code)
            MAP_2W_18_14: map_decode = 4'h1;
            MAP_2W_20_16: map_decode = 4'h2;
            MAP_1W:       map_decode = 4'h4;
            MAP_HALF_W:   map_decode = 4'h8;
            default:      map_decode = 4'h0;
        endcase
    endfunction

    function automatic logic [2:0] sel_decode(input logic [2:0] code);
        sel_decode = 3'h0;
        unique case (code)
            SEL_2W:     sel_decode = 3'h1;
            SEL_1W:     sel_decode = 3'h2;
            SEL_HALF_W: sel_decode = 3'h4;
            default:    sel_decode = 3'h0;
        endcase
    endfunction

    logic        sclk_s;
    logic        sen_n_s;
    logic        sdi_s;
    logic        sclk_rise;
    logic        sclk_fall;
    logic [14:0] addr;
    logic        rd;
    logic [7:0]  wdata;
    logic [7:0]  rdata;
    logic [2:0]  sel_dec;
    logic [2:0]  fuse_dec;

    assign sclk_s    = pins[2];
    assign sen_n_s   = ~pins[1];
    assign sdi_s     = pins[0];
    assign sclk_rise = sclk_s & ~r.sclk_q;
    assign sclk_fall = ~sclk_s & r.sclk_q;
    assign rd        = r.shift_in[15];
    assign addr      = r.shift_in[14:0];
    assign wdata     = {r.shift_in[6:0], sdi_s};
    assign sel_dec   = sel_decode(r.interface_selection);
    assign fuse_dec  = sel_decode(fuse_interface_selection);

    // Read mux; reserved bits read zero
    always_comb begin
        rdata = RST_BYTE;
        unique case (r.shift_in[14:0])
            OFS_IFACE_CFG:    rdata = {r.lane_bit_mapping, 1'b0,
                                       r.interface_change_permit, r.interface_selection};
            OFS_POWER_DOWN:   rdata = {2'b00, r.clkbuf_pd, r.refamp_pd, 1'b0,
                                       r.cha_pd, r.chb_pd, r.sleep};
            OFS_DRV_DIS_LOW:  rdata = r.drv_dis[7:0];
            OFS_DRV_DIS_MID:  rdata = r.drv_dis[15:8];
            OFS_DRV_DIS_HIGH: rdata = r.drv_dis[23:16];
            OFS_SLEEP_MASK:   rdata = {4'h0, r.keep_clock_buffer_in_sleep, 3'b000};
            default:          rdata = RST_BYTE;
        endcase
    end

    always_comb begin
        next_r            = r;
        next_r.sclk_q     = sclk_s;
        next_r.wr_pulse   = 1'b0;
        next_r.fuse_pulse = 1'b0;
        unique case (r.state)
            ST_IDLE: begin
                next_r.sdo_oe  = 1'b0;
                next_r.bit_cnt = 5'h00;
                if (!sen_n_s) begin
                    next_r.state = ST_CMD;
                end
            end
            ST_CMD: begin
                if (sclk_rise) begin
                    next_r.shift_in = {r.shift_in[21:0], sdi_s};
                    next_r.bit_cnt  = r.bit_cnt + 5'h01;
                    if (r.bit_cnt == CMD_LAST_CNT) begin
                        next_r.state = ST_DATA;
                    end
                end
            end
            ST_DATA: begin
                if (r.bit_cnt == 5'(FRAME_CMD_BITS) && rd && !r.sdo_oe) begin
                    next_r.shift_out = rdata;
                    next_r.sdo_oe    = 1'b1;
                end
                if (sclk_fall && r.sdo_oe) begin
                    next_r.sdo       = r.shift_out[7];
                    next_r.shift_out = {r.shift_out[6:0], 1'b0};
                end
                if (sclk_rise) begin
                    next_r.shift_in = {r.shift_in[21:0], sdi_s};
                    next_r.bit_cnt  = r.bit_cnt + 5'h01;
                    if (r.bit_cnt == FRAME_LAST_CNT) begin
                        next_r.state    = ST_DONE;
                        // Realign so rd and address sit at [15:0] again
                        next_r.shift_in = {7'h00, r.shift_in[22:7]};
                        if (!r.shift_in[22]) begin
                            next_r.wr_pulse = 1'b1;
                            // Reserved bits dropped on write
                            unique case (r.shift_in[21:7])
                                OFS_IFACE_CFG: begin
                                    next_r.lane_bit_mapping        = wdata[7:5];
                                    next_r.interface_change_permit = wdata[POS_PERMIT];
                                    next_r.interface_selection     = wdata[2:0];
                                end
                                OFS_POWER_DOWN: begin
                                    next_r.clkbuf_pd = wdata[POS_CLKBUF_OFF];
                                    next_r.refamp_pd = wdata[POS_REFAMP_OFF];
                                    next_r.cha_pd    = wdata[POS_CHA_OFF];
                                    next_r.chb_pd    = wdata[POS_CHB_OFF];
                                    next_r.sleep     = wdata[POS_SLEEP];
                                end
                                OFS_DRV_DIS_LOW:  next_r.drv_dis[7:0]   = wdata;
                                OFS_DRV_DIS_MID:  next_r.drv_dis[15:8]  = wdata;
                                OFS_DRV_DIS_HIGH: next_r.drv_dis[23:16] = wdata;
                                OFS_SLEEP_MASK: begin
                                    next_r.keep_clock_buffer_in_sleep = wdata[POS_KEEP_CLKBUF];
                                end
                                OFS_FUSE_LOAD: begin
                                    next_r.fuse_pulse = wdata[POS_FUSE_LOAD];
                                end
                                default: begin
                                end
                            endcase
                        end
                    end
                end
            end
            ST_DONE: begin
                if (sclk_fall && r.sdo_oe) begin
                    next_r.sdo = 1'b0;
                end
            end
        endcase
        if (sen_n_s) begin
            next_r.state  = ST_IDLE;
            next_r.sdo_oe = 1'b0;
            next_r.sdo    = 1'b0;
        end
        // Fuse load reloads mapping and clears power-down, driver-disable and sleep-mask writes
        if (r.fuse_pulse) begin
            next_r.active_map = (r.lane_bit_mapping != RST_FIELD3) ?
                                r.lane_bit_mapping : fuse_lane_mapping;
            next_r.clkbuf_pd                  = 1'b0;
            next_r.refamp_pd                  = 1'b0;
            next_r.cha_pd                     = 1'b0;
            next_r.chb_pd                     = 1'b0;
            next_r.sleep                      = 1'b0;
            next_r.drv_dis                    = RST_DRV_DIS;
            next_r.keep_clock_buffer_in_sleep = 1'b0;
        end
        next_r.lane_mode      = map_decode(r.active_map);
        next_r.interface_mode = (r.interface_change_permit && sel_dec != 3'h0) ?
                                sel_dec : fuse_dec;
        next_r.off_vec[4] = r.clkbuf_pd |
                            (r.sleep & ~r.keep_clock_buffer_in_sleep);
        next_r.off_vec[3] = r.refamp_pd | r.sleep;
        next_r.off_vec[2] = r.cha_pd | r.sleep;
        next_r.off_vec[1] = r.chb_pd | r.sleep;
        next_r.off_vec[0] = r.sleep;
        next_r.drv_out    = r.drv_dis;
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            r            <= '0;
            r.state      <= ST_IDLE;
            r.active_map <= fuse_lane_mapping;
        end else begin
            r <= next_r;
        end
    end

    assign spi_sdo                 = r.sdo;
    assign spi_sdo_oe              = r.sdo_oe;
    assign lane_mode               = r.lane_mode;
    assign interface_mode          = r.interface_mode;
    assign sample_clock_buffer_off = r.off_vec[4];
    assign reference_amp_off       = r.off_vec[3];
    assign channel_a_off           = r.off_vec[2];
    assign channel_b_off           = r.off_vec[1];
    assign whole_chip_sleep        = r.off_vec[0];
    assign output_driver_disable   = r.drv_out;

    logic cfg_written;
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            cfg_written <= 1'b0;
        end else if (r.wr_pulse && addr == OFS_IFACE_CFG) begin
            cfg_written <= 1'b1;
        end
    end

    sequence s_fuse_cmd;
        r.fuse_pulse;
    endsequence

    sequence s_sleep_set;
        r.sleep && !r.fuse_pulse;
    endsequence

    chk_map_fuse_apply: assert property (@(posedge ref_clk) disable iff (reset)
        s_fuse_cmd |=> (r.active_map == ($past(r.lane_bit_mapping) != 3'h0 ?
                        $past(r.lane_bit_mapping) : $past(fuse_lane_mapping))))
        else $error("mapping not applied at fuse load");
    chk_map_hold: assert property (@(posedge ref_clk) disable iff (reset)
        !r.fuse_pulse |=> $stable(r.active_map))
        else $error("mapping changed without fuse load");
    chk_map_decode: assert property (@(posedge ref_clk) disable iff (reset)
        (r.active_map == MAP_1W) ##1 (r.active_map == MAP_1W) |-> lane_mode == 4'h4)
        else $error("one-wire mapping decoded wrong");
    chk_cfg_zero_read: assert property (@(posedge ref_clk) disable iff (reset)
        !(cfg_written || (r.wr_pulse && addr == OFS_IFACE_CFG))
        |-> (r.lane_bit_mapping == 3'h0 && r.interface_selection == 3'h0))
        else $error("config field nonzero before write");
    chk_sel_permit: assert property (@(posedge ref_clk) disable iff (reset)
        !r.interface_change_permit |=> interface_mode == $past(fuse_dec))
        else $error("selection overrode default without permit");
    chk_sel_decode: assert property (@(posedge ref_clk) disable iff (reset)
        (r.interface_change_permit && r.interface_selection == SEL_HALF_W)
        |=> interface_mode == 3'h4)
        else $error("half-wire selection decoded wrong");
    chk_clkbuf_off: assert property (@(posedge ref_clk) disable iff (reset)
        r.clkbuf_pd |=> sample_clock_buffer_off)
        else $error("clock buffer not powered down");
    chk_sleep_keep: assert property (@(posedge ref_clk) disable iff (reset)
        (s_sleep_set ##0 (!r.clkbuf_pd && r.keep_clock_buffer_in_sleep))
        |=> !sample_clock_buffer_off && whole_chip_sleep)
        else $error("kept clock buffer switched off in sleep");
    chk_sleep_mask0: assert property (@(posedge ref_clk) disable iff (reset)
        (s_sleep_set ##0 !r.keep_clock_buffer_in_sleep) |=> sample_clock_buffer_off)
        else $error("clock buffer running in sleep");
    chk_refamp_off: assert property (@(posedge ref_clk) disable iff (reset)
        reference_amp_off == $past(r.refamp_pd | r.sleep))
        else $error("reference amp state wrong");
    chk_chan_off: assert property (@(posedge ref_clk) disable iff (reset)
        (channel_a_off == $past(r.cha_pd | r.sleep)) &&
        (channel_b_off == $past(r.chb_pd | r.sleep)))
        else $error("channel power state wrong");
    chk_sleep_out: assert property (@(posedge ref_clk) disable iff (reset)
        whole_chip_sleep == $past(r.sleep))
        else $error("sleep output wrong");
    chk_drv_write: assert property (@(posedge ref_clk) disable iff (reset)
        (r.wr_pulse && addr == OFS_DRV_DIS_MID && !r.fuse_pulse)
        |=> ##1 output_driver_disable[15:8] == $past(r.drv_dis[15:8]))
        else $error("driver disable not forwarded");
endmodule

// ---- hw/opd_sync.sv ----
`timescale 1ns/100ps
module opd_sync #(
    parameter int W = 3
) (
    input  wire logic         ref_clk,
    input  wire logic         reset,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } opd_sync_st_t;

    opd_sync_st_t r;
    opd_sync_st_t next_r;

    // Two stages; only the second is read
    always_comb begin
        next_r    = r;
        next_r.s1 = async_in;
        next_r.s2 = r.s1;
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign sync_out = r.s2;
endmodule

// ---- tb/opd_host.sv ----
`timescale 1ns/100ps
module opd_host (
    input  wire logic        ref_clk,
    output logic             spi_sclk,
    output logic             spi_sen_n,
    output logic             spi_sdi,
    input  wire logic        spi_sdo,
    input  wire logic        spi_sdo_oe,
    output logic [7:0]       rd_data,
    output logic             rd_done
);
    initial begin
        spi_sclk  = 1'b0;
        spi_sen_n = 1'b1;
        spi_sdi   = 1'b0;
        rd_data   = 8'h00;
        rd_done   = 1'b0;
    end

    // One frame, MSB first, each clock level held five cycles
    task automatic xfer(input int n, input logic [23:0] w);
        logic [7:0] d;
        d = 8'h00;
        @(posedge ref_clk) #1;
        spi_sen_n = 1'b0;
        for (int i = 0; i < n; i++) begin
            spi_sdi = w[23-i];
            repeat (5) @(posedge ref_clk);
            #1 spi_sclk = 1'b1;
            if (i >= 16) begin
                d = {d[6:0], (spi_sdo_oe === 1'b1) ? spi_sdo : 1'bx};
            end
            repeat (5) @(posedge ref_clk);
            #1 spi_sclk = 1'b0;
        end
        repeat (5) @(posedge ref_clk);
        #1 spi_sen_n = 1'b1;
        spi_sdi = ~spi_sdi;
        repeat (5) @(posedge ref_clk);
        if (w[23] && n == 24) begin
            rd_data = d;
            @(posedge ref_clk) #1 rd_done = 1'b1;
            @(posedge ref_clk) #1 rd_done = 1'b0;
        end
    endtask
endmodule

// ---- tb/tb_output_mode_and_powerdown_regs.sv ----
`timescale 1ns/100ps
module tb_output_mode_and_powerdown_regs;
    import opd_pkg::*;
    typedef struct {logic [35:0] exp; logic rd; logic [14:0] addr;} opd_note_t;
    logic        ref_clk = 1'b0;
    logic        reset = 1'b1;
    logic        spi_sclk, spi_sen_n, spi_sdi, spi_sdo, spi_sdo_oe, rd_done, snap = 1'b0;
    logic [2:0]  fmap = MAP_2W_20_16;
    logic [2:0]  fsel = SEL_1W;
    logic [3:0]  lane_mode;
    logic [2:0]  interface_mode;
    logic        clkbuf_off, ref_off, cha_off, chb_off, sleep;
    logic [23:0] drv_dis;
    logic [7:0]  rd_data, cfg = 8'h00, pd = 8'h00, mask = 8'h00;
    logic [23:0] drv = 24'h00_0000;
    logic [2:0]  amap;
    logic [35:0] outs;
    opd_note_t   q[$];
    opd_note_t   n;
    int          failures = 0;
    int          comparisons = 0;
    int          seed = 34382;

    always #2.5 ref_clk = ~ref_clk;
    assign outs = {lane_mode, interface_mode, clkbuf_off, ref_off, cha_off, chb_off, sleep,
                   drv_dis};

    opd_regs u_dut (.ref_clk(ref_clk), .reset(reset), .spi_sclk(spi_sclk),
        .spi_sen_n(spi_sen_n), .spi_sdi(spi_sdi), .spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe),
        .fuse_lane_mapping(fmap), .fuse_interface_selection(fsel), .lane_mode(lane_mode),
        .interface_mode(interface_mode), .sample_clock_buffer_off(clkbuf_off),
        .reference_amp_off(ref_off), .channel_a_off(cha_off), .channel_b_off(chb_off),
        .whole_chip_sleep(sleep), .output_driver_disable(drv_dis));
    opd_host u_host (.ref_clk(ref_clk), .spi_sclk(spi_sclk), .spi_sen_n(spi_sen_n),
        .spi_sdi(spi_sdi), .spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe), .rd_data(rd_data),
        .rd_done(rd_done));

    function automatic logic [35:0] exp_out();
        logic [2:0] s;
        logic [3:0] lm;
        logic [2:0] im;
        s  = (cfg[3] && cfg[2:0] >= SEL_2W && cfg[2:0] <= SEL_HALF_W) ? cfg[2:0] : fsel;
        lm = (amap >= MAP_2W_18_14 && amap <= MAP_HALF_W) ? 4'h1 << (amap - 3'h1) : 4'h0;
        im = (s >= SEL_2W && s <= SEL_HALF_W) ? 3'h1 << (s - 3'h3) : 3'h0;
        return {lm, im, pd[5] | (pd[0] & ~mask[3]), pd[4] | pd[0], pd[2] | pd[0],
                pd[1] | pd[0], pd[0], drv};
    endfunction

    function automatic logic [7:0] exp_rd(input logic [14:0] a);
        case (a)
            OFS_IFACE_CFG:    return cfg & 8'hEF;
            OFS_POWER_DOWN:   return pd & 8'h37;
            OFS_DRV_DIS_LOW:  return drv[7:0];
            OFS_DRV_DIS_MID:  return drv[15:8];
            OFS_DRV_DIS_HIGH: return drv[23:16];
            OFS_SLEEP_MASK:   return mask & 8'h08;
            default:          return 8'h00;
        endcase
    endfunction

    task automatic chk_outs();
        q.push_back('{exp_out(), 1'b0, 15'h0000});
        @(posedge ref_clk) #1 snap = 1'b1;
        @(posedge ref_clk) #1 snap = 1'b0;
    endtask

    task automatic rd(input logic [14:0] a);
        q.push_back('{{28'h000_0000, exp_rd(a)}, 1'b1, a});
        u_host.xfer(24, {1'b1, a, 8'h00});
    endtask

    task automatic wr(input logic [14:0] a, input logic [7:0] d);
        u_host.xfer(24, {1'b0, a, d});
        case (a)
            OFS_IFACE_CFG:    cfg = d;
            OFS_POWER_DOWN:   pd = d;
            OFS_DRV_DIS_LOW:  drv[7:0] = d;
            OFS_DRV_DIS_MID:  drv[15:8] = d;
            OFS_DRV_DIS_HIGH: drv[23:16] = d;
            OFS_SLEEP_MASK:   mask = d;
            OFS_FUSE_LOAD: if (d[0]) begin
                amap = (cfg[7:5] != 3'h0) ? cfg[7:5] : fmap;
                pd   = 8'h00;
                drv  = 24'h00_0000;
                mask = 8'h00;
            end
            default: ;
        endcase
        chk_outs();
    endtask

    task automatic summarize();
        $display("comparisons=%0d failures=%0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Scoreboard: oldest note against what the outputs or the read show
    always @(posedge ref_clk) begin
        if (snap || rd_done) begin
            n = q.pop_front();
            comparisons++;
            if (n.exp !== (snap ? outs : {28'h000_0000, rd_data})) begin
                $display("ERROR %s 0x%h expected %h seen %h", n.rd ? "read" : "outputs",
                         n.addr, n.exp, snap ? outs : {28'h000_0000, rd_data});
                failures++;
            end
        end
    end

    initial begin
        repeat (40000) @(posedge ref_clk);
        failures++;
        summarize();
    end

    initial begin
        amap = fmap;
        repeat (12) @(posedge ref_clk);
        #1 reset = 1'b0;
        repeat (4) @(posedge ref_clk);
        chk_outs();
        rd(OFS_IFACE_CFG);
        for (int m = 0; m < 8; m++) begin
            wr(OFS_IFACE_CFG, {m[2:0], 5'h00});
            wr(OFS_FUSE_LOAD, 8'h01);
            rd(OFS_IFACE_CFG);
        end
        for (int s = 0; s < 16; s++) begin
            wr(OFS_IFACE_CFG, {3'h1, 1'b0, s[3], s[2:0]});
        end
        for (int r = 0; r < 3; r++) begin
            wr(OFS_DRV_DIS_LOW + 15'(r), 8'($random(seed)));
            rd(OFS_DRV_DIS_LOW + 15'(r));
        end
        for (int b = 0; b < 8; b++) begin
            wr(OFS_POWER_DOWN, 8'h01 << b);
        end
        wr(OFS_SLEEP_MASK, 8'hFF);
        wr(OFS_POWER_DOWN, 8'h01);
        wr(OFS_POWER_DOWN, 8'hFF);
        rd(OFS_POWER_DOWN);
        rd(OFS_SLEEP_MASK);
        wr(15'h0055, 8'hFF);
        rd(15'h0055);
        rd(OFS_FUSE_LOAD);
        u_host.xfer(16, {1'b0, OFS_DRV_DIS_HIGH, 8'hFF});
        chk_outs();
        wr(OFS_FUSE_LOAD, 8'h01);
        // Second reset in mid-run with other fuse defaults
        @(posedge ref_clk) #1 reset = 1'b1;
        fmap = 3'($random(seed));
        fsel = 3'($random(seed));
        amap = fmap;
        cfg  = 8'h00;
        pd   = 8'h00;
        mask = 8'h00;
        drv  = 24'h00_0000;
        repeat (12) @(posedge ref_clk);
        #1 reset = 1'b0;
        repeat (4) @(posedge ref_clk);
        chk_outs();
        rd(OFS_IFACE_CFG);
        wr(OFS_IFACE_CFG, 8'h00);
        wr(OFS_FUSE_LOAD, 8'h01);
        summarize();
    end
endmodule
